// ---- dio_defines.svh ----
// register map, field positions and reset values of the ddr io cell
// assumes byte addresses on a 32-bit classic wishbone bus
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH
// ***********************************
// register offsets
// ***********************************
`define DIO_CTRL_ADR   8'h00
`define DIO_CFG_ADR    8'h04
`define DIO_STATUS_ADR 8'h08
// ***********************************
// control register fields and reset
// ***********************************
`define DIO_CTRL_MODE_LSB 0
`define DIO_CTRL_INIT_BIT 2
`define DIO_CTRL_SWOE_BIT 3
`define DIO_CTRL_SWCL_BIT 4
`define DIO_CTRL_DLY_LSB  5
`define DIO_CTRL_W        7
`define DIO_CTRL_RST      7'h00
// ***********************************
// clocking configuration fields and reset
// ***********************************
`define DIO_CFG_ICLK_LSB 0
`define DIO_CFG_OCLK_LSB 2
`define DIO_CFG_ICE_LSB  4
`define DIO_CFG_OCE_LSB  7
`define DIO_CFG_OE_LSB   10
`define DIO_CFG_CLR_LSB  14
`define DIO_CFG_W        16
`define DIO_CFG_RST      16'h0FF0
`endif

// ---- dio_pkg.sv ----
// types shared by the ddr io cell
// assumes dio_defines.svh holds the numbers
package dio_pkg;
   // cell operating modes
   typedef enum logic [1:0] {DIO_SINGLE, DIO_DDR_IN, DIO_DDR_OUT, DIO_DDR_BIDIR} dio_mode_e;
   // input delay element setting
   typedef logic [1:0] dio_dly_t;
endpackage

// ---- dio_cell.sv ----
// one bidirectional ddr io cell with a wishbone register port
// assumes one 40 MHz clock; pins and control lines synchronous to it
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "dio_defines.svh"
module dio_cell
   import dio_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [5:0]  i_pcb_oe,
   input  wire logic [5:0]  i_pcb_ce,
   input  wire logic        i_pad,
   output logic             o_pad,
   output logic             o_pad_oe,
   input  wire logic        i_tx_valid,
   input  wire logic [1:0]  i_tx_data,
   output logic             o_tx_ready,
   output logic             o_rx_valid,
   output logic [1:0]       o_rx_data,
   input  wire logic        i_rx_ready
);
   // ***********************************
   // declarations
   // ***********************************
   logic [`DIO_CTRL_W-1:0] ctrl_reg;        // mode, init level, sw oe/clear, delay
   logic [`DIO_CFG_W-1:0]  cfg_reg;         // clock, enable, oe and clear selects
   logic [31:0]            rdat_reg;        // read data held with ack
   logic                   ack_reg;         // one-cycle bus answer
   logic                   int_clk_reg;     // divided cell clock, half rate
   logic                   iclk_prev_reg;   // last input clock level
   logic                   oclk_prev_reg;   // last output clock level
   logic [2:0]             dly_reg;         // input delay chain taps
   logic                   in_a_reg;        // rising-edge input register
   logic                   in_b_reg;        // falling-edge input register
   logic                   latch_reg;       // holds the rising bit
   logic                   out_a_reg;       // first output bit
   logic                   out_b_reg;       // second output bit
   logic                   oe_pos_reg;      // rising-edge oe register
   logic                   oe_neg_reg;      // falling-edge oe register
   logic                   pad_reg;         // registered pin drive
   logic                   pad_oe_reg;      // registered pin enable
   logic                   push_reg;        // capture word ready to push
   logic [1:0]             word_reg;        // captured word
   logic                   tx_rdy_reg;      // core may hand a pair
   logic                   head_v_reg;      // buffer head valid
   logic [1:0]             head_reg;        // buffer head word
   logic                   tail_v_reg;      // buffer second entry valid
   logic [1:0]             tail_reg;        // buffer second entry word
   // ***********************************
   // decode and selection
   // ***********************************
   dio_mode_e mode_w;
   dio_dly_t  dly_w;
   wire       req_w    = i_wb_cyc & i_wb_stb & ~ack_reg;
   wire       wr_w     = req_w & i_wb_we;
   wire       ctrl_hit = (i_wb_adr == `DIO_CTRL_ADR);
   wire       cfg_hit  = (i_wb_adr == `DIO_CFG_ADR);
   wire       stat_hit = (i_wb_adr == `DIO_STATUS_ADR);
   assign mode_w = dio_mode_e'(ctrl_reg[`DIO_CTRL_MODE_LSB +: 2]);
   assign dly_w  = ctrl_reg[`DIO_CTRL_DLY_LSB +: 2];
   wire       init_w   = ctrl_reg[`DIO_CTRL_INIT_BIT];
   wire [1:0] iclk_sel = cfg_reg[`DIO_CFG_ICLK_LSB +: 2];
   wire [1:0] oclk_sel = cfg_reg[`DIO_CFG_OCLK_LSB +: 2];
   wire [2:0] ice_sel  = cfg_reg[`DIO_CFG_ICE_LSB +: 3];
   wire [2:0] oce_sel  = cfg_reg[`DIO_CFG_OCE_LSB +: 3];
   wire [3:0] oe_sel   = cfg_reg[`DIO_CFG_OE_LSB +: 4];
   wire [1:0] clr_sel  = cfg_reg[`DIO_CFG_CLR_LSB +: 2];
   // only ce0 and ce2 may stand in as a cell clock
   wire iclk_w = (iclk_sel == 2'h1) ? i_pcb_ce[0] :
                 (iclk_sel == 2'h2) ? i_pcb_ce[2] : int_clk_reg;
   wire oclk_w = (oclk_sel == 2'h1) ? i_pcb_ce[0] :
                 (oclk_sel == 2'h2) ? i_pcb_ce[2] : int_clk_reg;
   // any of the six ce lines gates a path; 6 and 7 mean always on
   wire ice_line = (ice_sel > 3'h5) ? 1'b1 : i_pcb_ce[ice_sel];
   wire oce_w    = (oce_sel > 3'h5) ? 1'b1 : i_pcb_ce[oce_sel];
   // oe from oe0..oe5, ce1, ce3 or software
   wire oe_src_w = (oe_sel < 4'h6)  ? i_pcb_oe[oe_sel[2:0]] :
                   (oe_sel == 4'h6) ? i_pcb_ce[1] :
                   (oe_sel == 4'h7) ? i_pcb_ce[3] : ctrl_reg[`DIO_CTRL_SWOE_BIT];
   // a single clear for the input and output registers: ce4, ce5 or software
   wire clr_w = (clr_sel == 2'h1) ? i_pcb_ce[4] :
                (clr_sel == 2'h2) ? i_pcb_ce[5] :
                (clr_sel == 2'h3) ? ctrl_reg[`DIO_CTRL_SWCL_BIT] : 1'b0;
   // edge events of the two cell clocks
   wire irise_w = iclk_w & ~iclk_prev_reg;
   wire ifall_w = ~iclk_w & iclk_prev_reg;
   wire orise_w = oclk_w & ~oclk_prev_reg;
   wire ofall_w = ~oclk_w & oclk_prev_reg;
   // a full buffer stalls capture so no word is lost
   wire ice_w   = ice_line & ~tail_v_reg;
   // delay element: off or one to three cycles
   wire pin_w   = (dly_w == 2'h0) ? i_pad : dly_reg[dly_w - 2'h1];
   wire ddr_in_w  = (mode_w == DIO_DDR_IN) | (mode_w == DIO_DDR_BIDIR);
   wire ddr_out_w = (mode_w == DIO_DDR_OUT) | (mode_w == DIO_DDR_BIDIR);
   wire take_w    = tx_rdy_reg & i_tx_valid;
   wire pop_w     = head_v_reg & i_rx_ready;
   wire [31:0] stat_w = {24'h000000, tail_v_reg, head_v_reg, oe_neg_reg, oe_pos_reg,
                         out_b_reg, out_a_reg, in_b_reg, in_a_reg};
   wire [31:0] rd_w   = ctrl_hit ? {25'h0, ctrl_reg} :
                        cfg_hit  ? {16'h0000, cfg_reg} :
                        stat_hit ? stat_w : 32'h00000000;
   // ***********************************
   // wishbone slave
   // ***********************************
   // answers every request one cycle later; unmapped reads give zero
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg  <= req_w;
         rdat_reg <= req_w ? rd_w : 32'h00000000;
      end
   end
   // control registers, low two byte lanes only
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         ctrl_reg <= `DIO_CTRL_RST;
         cfg_reg  <= `DIO_CFG_RST;
      end
      else if (wr_w && ctrl_hit && i_wb_sel[0])
      begin
         ctrl_reg <= i_wb_dat[`DIO_CTRL_W-1:0];
      end
      else if (wr_w && cfg_hit)
      begin
         if (i_wb_sel[0])
            cfg_reg[7:0] <= i_wb_dat[7:0];
         if (i_wb_sel[1])
            cfg_reg[15:8] <= i_wb_dat[15:8];
      end
   end
   // ***********************************
   // clocking and delay chain
   // ***********************************
   // divider makes the half-rate cell clock; previous levels find edges
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         int_clk_reg   <= 1'b0;
         iclk_prev_reg <= 1'b0;
         oclk_prev_reg <= 1'b0;
         dly_reg       <= 3'h0;
      end
      else
      begin
         int_clk_reg   <= ~int_clk_reg;
         iclk_prev_reg <= iclk_w;
         oclk_prev_reg <= oclk_w;
         dly_reg       <= {dly_reg[1:0], i_pad};
      end
   end
   // ***********************************
   // input registers and latch
   // ***********************************
   // clear wins over every clocked load; it lands on the programmed level
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         in_a_reg  <= 1'b0;
         in_b_reg  <= 1'b0;
         latch_reg <= 1'b0;
         push_reg  <= 1'b0;
         word_reg  <= 2'h0;
      end
      else if (clr_w)
      begin
         in_a_reg  <= init_w;
         in_b_reg  <= init_w;
         latch_reg <= init_w;
         push_reg  <= 1'b0;
      end
      else
      begin
         push_reg <= 1'b0;
         if (irise_w && ice_w && mode_w != DIO_DDR_OUT)
         begin
            in_a_reg <= pin_w;
            if (!ddr_in_w)
            begin
               // single rate: one bit per rising edge
               push_reg <= 1'b1;
               word_reg <= {1'b0, pin_w};
            end
         end
         if (ifall_w && ice_w && ddr_in_w)
         begin
            in_b_reg  <= pin_w;
            latch_reg <= in_a_reg;
            push_reg  <= 1'b1;
            word_reg  <= {in_a_reg, pin_w};
         end
         // a disabled enable leaves every register but push_reg as it is
      end
   end
   // ***********************************
   // output and oe registers
   // ***********************************
   // output pair loads on the hand-off the cycle after a rise, oe on the rise and then the fall, all under one shared enable
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         out_a_reg  <= 1'b0;
         out_b_reg  <= 1'b0;
         oe_pos_reg <= 1'b0;
         oe_neg_reg <= 1'b0;
         tx_rdy_reg <= 1'b0;
      end
      else if (clr_w)
      begin
         out_a_reg  <= init_w;
         out_b_reg  <= init_w;
         oe_pos_reg <= init_w;
         oe_neg_reg <= init_w;
         tx_rdy_reg <= 1'b0;
      end
      else
      begin
         // ready the cycle after a rise, so the pair loads on the hand-off one cycle after that rise;
         // a level test would fire in every high cycle of a slow ce0 or ce2 clock
         tx_rdy_reg <= oce_w & orise_w;
         if (take_w)
         begin
            out_a_reg <= i_tx_data[0];
            out_b_reg <= i_tx_data[1];
         end
         if (orise_w && oce_w)
            oe_pos_reg <= oe_src_w;
         if (ofall_w && oce_w)
            oe_neg_reg <= oe_pos_reg;
      end
   end
   // ***********************************
   // pin drive
   // ***********************************
   // one cycle of pipeline, traded for a glitch-free registered pin
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         pad_reg    <= 1'b0;
         pad_oe_reg <= 1'b0;
      end
      else
      begin
         // first bit while clock high, second while low
         pad_reg <= (ddr_out_w && !oclk_w) ? out_b_reg : out_a_reg;
         if (mode_w == DIO_DDR_IN)
            pad_oe_reg <= 1'b0;
         else if (ddr_out_w)
            pad_oe_reg <= oe_neg_reg;
         else
            pad_oe_reg <= oe_pos_reg;
      end
   end
   // ***********************************
   // two-entry receive buffer
   // ***********************************
   // head feeds the core; tail catches one word while the core stalls
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         head_v_reg <= 1'b0;
         tail_v_reg <= 1'b0;
         head_reg   <= 2'h0;
         tail_reg   <= 2'h0;
      end
      else if (pop_w && tail_v_reg)
      begin
         head_reg   <= tail_reg;
         tail_v_reg <= 1'b0;
      end
      else if (pop_w || !head_v_reg)
      begin
         head_v_reg <= push_reg;
         head_reg   <= push_reg ? word_reg : head_reg;
      end
      else if (push_reg)
      begin
         tail_v_reg <= 1'b1;
         tail_reg   <= word_reg;
      end
   end
   // ***********************************
   // outputs
   // ***********************************
   assign o_wb_ack   = ack_reg;
   assign o_wb_dat   = rdat_reg;
   assign o_pad      = pad_reg;
   assign o_pad_oe   = pad_oe_reg;
   assign o_tx_ready = tx_rdy_reg;
   assign o_rx_valid = head_v_reg;
   assign o_rx_data  = head_reg;
endmodule

// ---- dio_cell_sva.sv ----
// checker for the ddr io cell: bus answer, stream hand-off, pad timing
// assumes every configuration write uses all four byte lanes
`timescale 1ns/1ps
`include "dio_defines.svh"
module dio_cell_sva
   import dio_pkg::*;
(
   input wire logic        i_clock,
   input wire logic        i_rst_b,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic [5:0]  i_pcb_oe,
   input wire logic [5:0]  i_pcb_ce,
   input wire logic        i_pad,
   input wire logic        o_pad,
   input wire logic        o_pad_oe,
   input wire logic        i_tx_valid,
   input wire logic [1:0]  i_tx_data,
   input wire logic        o_tx_ready,
   input wire logic        o_rx_valid,
   input wire logic [1:0]  o_rx_data,
   input wire logic        i_rx_ready
);
   // ***********************************
   // shadow of the configuration writes
   // ***********************************
   logic [6:0]  ctrl_reg;  // last control word taken
   logic [15:0] cfg_reg;   // last clocking word taken
   logic [2:0]  age_reg;   // cycles since a write, saturates at 7
   wire take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   // a fresh write may still be working through the cell
   wire settled = (age_reg == 3'h7);
   wire plain = (cfg_reg[15:14] == 2'h0) && (cfg_reg[9:7] > 3'h5) && (cfg_reg[3:2] == 2'h0);
   // follow writes at the edge that takes them
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         age_reg <= 3'h0;
      else if (take)
         age_reg <= 3'h0;
      else if (!settled)
         age_reg <= age_reg + 3'h1;
   end
   // field shadows, reset values as the cell
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         ctrl_reg <= `DIO_CTRL_RST;
      else if (take && i_wb_adr == `DIO_CTRL_ADR)
         ctrl_reg <= i_wb_dat[6:0];
   end
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         cfg_reg <= `DIO_CFG_RST;
      else if (take && i_wb_adr == `DIO_CFG_ADR)
         cfg_reg <= i_wb_dat[15:0];
   end
   // ***********************************
   // properties
   // ***********************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   sequence bus_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence pair_taken;
      i_tx_valid && o_tx_ready && ctrl_reg[1] && plain && settled;
   endsequence
   // first bit while the clock is low, second while high
   sequence pad_pair;
      ##2 (o_pad == $past(i_tx_data[0], 2)) ##1 (o_pad == $past(i_tx_data[1], 3));
   endsequence
   bus_answer_a: assert property (bus_req |=> o_wb_ack)
      else $error("bus request without ack one cycle later");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   idle_data_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
      else $error("read data not zero outside ack");
   rx_hold_a: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
      else $error("stalled rx word lost or changed");
   ready_pulse_a: assert property (o_tx_ready |=> !o_tx_ready)
      else $error("tx ready longer than one cycle");
   pad_order_a: assert property (pair_taken |-> pad_pair)
      else $error("ddr output bits out of order on pad");
   ddr_in_quiet_a: assert property (settled && ctrl_reg[1:0] == DIO_DDR_IN |-> !o_pad_oe)
      else $error("pad driven in ddr input mode");
   oe_fall_a: assert property (settled && plain && ctrl_reg[1] && $changed(o_pad_oe) |=> $stable(o_pad_oe))
      else $error("pad enable changed off the falling edge");
endmodule
bind dio_cell dio_cell_sva chk_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pcb_oe(i_pcb_oe),
   .i_pcb_ce(i_pcb_ce), .i_pad(i_pad), .o_pad(o_pad), .o_pad_oe(o_pad_oe),
   .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
   .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready));

// ---- dio_mem_model.sv ----
// far-side memory model driving the shared data pin
// assumes the pin has no pull; the cell wins while it drives
`timescale 1ns/1ps
module dio_mem_model
(
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   input  wire logic i_drive,
   input  wire logic i_cell_pad,
   input  wire logic i_cell_oe,
   output logic      o_pin
);
   logic bit_reg;   // memory data, a new bit every half cell period
   logic last_reg;  // last pin level, inverted once released
   // two bits per cell period at double rate
   always_ff @(posedge i_clock)
   begin
      bit_reg <= i_rst_b ? ~bit_reg : 1'b0;
      last_reg <= o_pin;
   end
   // turnaround with no idle cycle either way
   assign o_pin = i_cell_oe ? i_cell_pad : (i_drive ? bit_reg : ~last_reg);
endmodule

// ---- dio_cell_tb.sv ----
// self-checking bench for the ddr io cell
// assumes the memory model on the pin and a bus master in the bench
`timescale 1ns/1ps
module dio_cell_tb
   import dio_pkg::*;
;
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, drive = 0, tx_valid = 0, rx_ready = 1;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [5:0] pcb_oe = 6'h00, pcb_ce = 6'h00;
   logic [1:0] tx_data = 2'h0, rx_data, w, w0;
   logic ack, pad_in, pad_out, pad_oe, tx_ready, rx_valid;
   int error_cnt = 0, comparisons = 0, n;
   always #12.5 clk = ~clk;  // 40 MHz
   dio_cell uut (.i_clock(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_pcb_oe(pcb_oe), .i_pcb_ce(pcb_ce), .i_pad(pad_in), .o_pad(pad_out), .o_pad_oe(pad_oe),
      .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready));
   dio_mem_model mem (.i_clock(clk), .i_rst_b(rst_b), .i_drive(drive), .i_cell_pad(pad_out),
      .i_cell_oe(pad_oe), .o_pin(pad_in));
   // ***********************************
   // shared tasks
   // ***********************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1; stb <= 1; we <= w_en; adr <= a; wdat <= d;
      @(posedge clk);
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
      chk("wb_ack", 1, ack);
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk);
   endtask
   task automatic pop();
      @(posedge clk);
      for (n = 0; n < 40 && rx_valid !== 1'b1; n++) @(posedge clk);
      chk("rx_valid", 1, rx_valid);
      w = rx_data;
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_regs();
      wb(0, 8'h00, 0); chk("ctrl", 32'h0, q);
      wb(0, 8'h04, 0); chk("cfg", 32'h0FF0, q);
      wb(1, 8'h0C, 32'hFFFF); wb(0, 8'h0C, 0); chk("unmapped", 32'h0, q);
      wb(1, 8'h00, 32'hFF80); wb(0, 8'h00, 0); chk("ctrl_upper", 32'h0, q);
   endtask
   task automatic t_tx();
      wb(1, 8'h04, 32'h23F0); wb(1, 8'h00, 32'h0A);
      repeat (8) @(posedge clk);
      chk("pad_oe", 1, pad_oe);
      for (int d = 0; d < 4; d++)
      begin
         tx_valid <= 1; tx_data <= d[1:0];
         @(posedge clk);
         for (n = 0; n < 20 && tx_ready !== 1'b1; n++) @(posedge clk);
         chk("tx_ready", 1, tx_ready);
         tx_valid <= 0;
         repeat (2) @(posedge clk);
         chk("pad_first", d[0], pad_out);
         @(posedge clk);
         chk("pad_second", d[1], pad_out);
      end
   endtask
   task automatic t_rx();
      drive <= 1;
      for (int d = 0; d < 4; d++)
      begin
         wb(1, 8'h00, (d << 5) | 1);
         repeat (5) pop();
         if (d == 0) w0 = w;
         chk("rx_edges", 1, w[1] ^ w[0]);
         chk("rx_delay", {2{d[0]}}, w ^ w0);
      end
      chk("pad_oe_in", 0, pad_oe);
      rx_ready <= 0;
      repeat (12) @(posedge clk);
      wb(0, 8'h08, 0); chk("buf_full", 2'h3, q[7:6]);
      rx_ready <= 1;
      repeat (3) pop();
      chk("rx_after_stall", 1, w[1] ^ w[0]);
      wb(1, 8'h04, 32'h2380); repeat (20) @(posedge clk); // input ce line 0 held low
      chk("rx_held", 0, rx_valid);
      drive <= 0;
   endtask
   task automatic t_clear();
      for (int k = 0; k < 2; k++)
      begin
         wb(1, 8'h04, ((k + 1) << 14) | 32'h23F0); wb(1, 8'h00, 32'h06);
         pcb_ce[4 + k] <= 1; repeat (4) @(posedge clk);
         wb(0, 8'h08, 0); chk("clear_high", 6'h3F, q[5:0]);
         wb(1, 8'h00, 32'h02); repeat (4) @(posedge clk);
         wb(0, 8'h08, 0); chk("clear_low", 6'h00, q[5:0]);
         pcb_ce[4 + k] <= 0;
      end
   endtask
   task automatic t_oe_line();
      for (int k = 0; k < 2; k++)
      begin
         wb(1, 8'h04, k ? 32'h1BF0 : 32'h07F0); wb(1, 8'h00, 32'h02);
         for (int v = 1; v >= 0; v--)
         begin
            if (k) pcb_ce[1] <= v[0]; else pcb_oe[1] <= v[0];
            repeat (8) @(posedge clk);
            chk("oe_line", v[0], pad_oe);
         end
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog, far beyond the expected few hundred cycles
   initial
   begin
      #(25 * 40000);
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      t_regs();
      t_tx();
      t_rx();
      t_clear();
      t_oe_line();
      give_verdict();
   end
endmodule
